// >>> vbi_data_capture_i2c_slave_tb_top.sv
// bench: controller and capture device joined over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module vbi_data_capture_i2c_slave_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic pin_sel, asel, line_valid, line_err, dr_n, fast, busy;
  logic [7:0] paddr, mode;
  logic [31:0] pwdata, prdata, rd;
  vdc_pkg::vdc_line_t line_kind;
  logic [207:0] line_data, f2, ln;
  logic [103:0] exp_b;
  int bad_count, n_compared;
  int cyc = 0;
  vdc_if vdc_if_inst ();
  vdc_host vdc_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_ready_n_in(dr_n), .link(vdc_if_inst.host));
  vdc_device vdc_device_inst (.pclk(pclk), .presetn(presetn), .link(vdc_if_inst.dev),
    .bus_addr_select_pin(pin_sel), .line_valid(line_valid), .line_kind(line_kind),
    .line_data(line_data), .line_biphase_err(line_err), .data_ready_n_out(dr_n),
    .mode_control_out(mode), .sys_clk_fast(fast), .bus_busy(busy));
  vdc_link_chk vdc_link_chk_inst (.pclk(pclk), .presetn(presetn), .scl(vdc_if_inst.scl),
    .host_sda_o(vdc_if_inst.host_sda_o), .host_sda_oe(vdc_if_inst.host_sda_oe),
    .dev_sda_o(vdc_if_inst.dev_sda_o), .dev_sda_oe(vdc_if_inst.dev_sda_oe),
    .sda(vdc_if_inst.sda));
  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) bad_count++;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, vdc_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[vdc_pkg::ST_DONE_BIT] !== 1'b1 && n < 2000);
    if (n == 2000) bad_count++;
  endtask
  // one link transfer: write of a control byte or read of len bytes
  task automatic xfer(input logic rdn, input logic [3:0] len, input logic [7:0] b);
    apb(1'b1, vdc_pkg::REG_TXBYTE, {24'h0, b});
    apb(1'b1, vdc_pkg::REG_CMD, {24'h0, len, 1'b0, asel, rdn, 1'b1});
    wait_done();
  endtask
  task automatic rd_chk(input logic [3:0] len, input logic [103:0] e);
    xfer(1'b1, len, 8'h00);
    for (int i = 0; i < len; i++) begin
      apb(1'b0, 8'(vdc_pkg::REG_RX_FIRST + 4 * i), 32'h0);
      chk("rx_byte", {24'h0, e[8*i +: 8]}, rd);
    end
  endtask
  task automatic put_line(input vdc_pkg::vdc_line_t k, input logic [207:0] d, input logic e);
    @(posedge pclk);
    line_valid <= 1'b1;
    line_kind <= k;
    line_data <= d;
    line_err <= e;
    @(posedge pclk);
    line_valid <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [207:0] mk(input logic [7:0] s);
    for (int i = 0; i < 26; i++) mk[8*i +: 8] = s + 8'(i * 37);
  endfunction
  // teletext hamming 8/4 with odd overall parity
  function automatic logic [7:0] ham(input logic [3:0] d);
    logic [7:0] h;
    h = {d[3], 1'b0, d[2], ~(d[0] ^ d[1] ^ d[2]), d[1], ~(d[0] ^ d[1] ^ d[3]), d[0],
      ~(d[0] ^ d[2] ^ d[3])};
    h[6] = ~(^h);
    return h;
  endfunction
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin_sel = 1'b0;
    asel = 1'b0;
    line_valid = 1'b0;
    line_kind = vdc_pkg::VDC_LK_NONE;
    line_data = '0;
    line_err = 1'b0;
    bad_count = 0;
    n_compared = 0;
    for (int j = 0; j < 26; j++) f2[8*j +: 8] = ham(4'(j * 5 + 3));
    for (int k = 0; k < 13; k++) exp_b[8*k +: 8] = {4'(k * 10 + 8), 4'(k * 10 + 3)};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("mode", 32'h0, {24'h0, mode});
    chk("dr_n", 32'h1, {31'h0, dr_n});
    chk("fast", 32'h0, {31'h0, fast});
    apb(1'b0, 8'h0C, 32'h0);
    chk("slverr", 32'h1, {31'h0, perr});
    // every pin and address pairing; only matching pairs acknowledge
    for (int s = 0; s < 4; s++) begin
      pin_sel <= s[1];
      asel = s[0];
      xfer(1'b0, 4'h0, 8'h02);
      chk("nack", {31'h0, s[1] == s[0]}, {31'h0, ~rd[vdc_pkg::ST_NACK_BIT]});
    end
    chk("mode", 32'h2, {24'h0, mode});
    chk("fast", 32'h1, {31'h0, fast});
    // teletext: line 16 ignored, format-2 single error corrected
    put_line(vdc_pkg::VDC_LK_LINE16, mk(8'h11), 1'b0);
    chk("dr_n", 32'h1, {31'h0, dr_n});
    put_line(vdc_pkg::VDC_LK_F2, f2 ^ (208'h8 << 40), 1'b0);
    chk("dr_n", 32'h0, {31'h0, dr_n});
    apb(1'b0, vdc_pkg::REG_STATUS, 32'h0);
    chk("ready", 32'h1, {31'h0, rd[vdc_pkg::ST_READY_BIT]});
    rd_chk(4'hD, exp_b);
    rd_chk(4'h3, exp_b);
    rd_chk(4'h2, exp_b);
    put_line(vdc_pkg::VDC_LK_F2, f2 ^ (208'h3 << 48), 1'b0);
    chk("dr_n", 32'h1, {31'h0, dr_n});
    // format-1 stored as received, header time padded
    xfer(1'b0, 4'h0, 8'h03);
    ln = mk(8'h40);
    put_line(vdc_pkg::VDC_LK_F1, ln, 1'b0);
    rd_chk(4'hD, ln[103:0]);
    xfer(1'b0, 4'h0, 8'h07);
    ln = mk(8'h80);
    put_line(vdc_pkg::VDC_LK_HEADER, ln, 1'b0);
    rd_chk(4'hD, {{5{8'hFF}}, ln[63:0]});
    // line 16: biphase error drops, clean line stores with a falling edge
    xfer(1'b0, 4'h0, 8'h00);
    chk("fast", 32'h0, {31'h0, fast});
    ln = mk(8'hC0);
    put_line(vdc_pkg::VDC_LK_LINE16, ln, 1'b1);
    chk("dr_n", 32'h1, {31'h0, dr_n});
    put_line(vdc_pkg::VDC_LK_LINE16, ln, 1'b0);
    chk("dr_n", 32'h0, {31'h0, dr_n});
    rd_chk(4'hD, ln[103:0]);
    // a line arriving during a bus access is dropped
    apb(1'b1, vdc_pkg::REG_CMD, {24'h0, 4'h0, 1'b0, asel, 2'b01});
    for (int n = 0; n < 200 && busy !== 1'b1; n++) @(posedge pclk);
    put_line(vdc_pkg::VDC_LK_LINE16, mk(8'h22), 1'b0);
    wait_done();
    chk("dr_n", 32'h1, {31'h0, dr_n});
    rd_chk(4'hD, ln[103:0]);
    summarize();
  end
endmodule
`default_nettype wire

// >>> vdc_device.sv
// capture device end: line acquisition, transfer register, bus slave
// Functional notes
// - clock rate follows mode: 10/13.875 MHz
// - teletext mode takes only 8/30 rows
// - format-1 bytes stored unchanged
// - format-2 Hamming checked, single errors corrected
// - format-2 store drives data-ready low
// - line 16 stored only without biphase errors
// - line 16 store gives high-to-low data-ready
// - no storage while bus access runs
// - slave only: never drives clock
// - master starts only on idle bus
// - data changes only while clock low
// - addresses 20h/21h or 22h/23h by pin
// - eight address bits, ninth slave acknowledge
// - write is one control byte, acked
// - control register resets to zero
// - software keeps test bits 3-7
// - bit 0 picks format-2 or alternate
// - bit 1 picks line-16 or teletext
// - bit 2 picks format-1 or header time
// - up to 13 bytes, msb first
// - read: bytes acked, last not acked
// - start resets pointer, ack advances it
// - no-ack ends transmission
`timescale 1ns/1ps
`default_nettype none
module vdc_device (
  input wire logic pclk,
  input wire logic presetn,
  vdc_if.dev link,
  input wire logic bus_addr_select_pin,
  input wire logic line_valid,
  input wire vdc_pkg::vdc_line_t line_kind,
  input wire logic [vdc_pkg::LINE_BITS-1:0] line_data,
  input wire logic line_biphase_err,
  output logic data_ready_n_out,
  output logic [7:0] mode_control_out,
  output logic sys_clk_fast,
  output logic bus_busy
);
  vdc_pkg::vdc_dev_state_t state;
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] sel_q;
  logic [7:0] mode_control;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [3:0] ptr;
  logic rw;
  logic ack_ok;
  logic sda_oe;
  logic [vdc_pkg::OUT_BITS-1:0] xfer;
  logic [3:0] ham_nib [0:vdc_pkg::NUM_HAM_BYTES-1];
  logic [vdc_pkg::NUM_HAM_BYTES-1:0] ham_bad;
  logic [vdc_pkg::OUT_BITS-1:0] f2_bytes;

  // bus line events, read only from the second and third stages
  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire sda_bit = sda_q[1];
  wire start_cond = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  wire stop_cond = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
  wire byte_done = (bitcnt == vdc_pkg::BITS_PER_BYTE);
  wire [6:0] my_addr = vdc_pkg::DEV_ADDR_BASE | {6'h0, sel_q[1]};
  wire addr_hit = (shreg[7:1] == my_addr);
  wire [7:0] cur_byte = (ptr <= vdc_pkg::LAST_PTR) ? xfer[{ptr, 3'b000} +: 8] :
    vdc_pkg::FILL_BYTE;
  wire rd_addr_acked = (state == vdc_pkg::VDC_D_ADDR_ACK) & scl_fall & rw;

  // Hamming 8/4 decode per received byte
  genvar g;
  generate
    for (g = 0; g < vdc_pkg::NUM_HAM_BYTES; g++) begin : g_ham
      wire [7:0] b = line_data[8*g +: 8];
      wire c0 = b[0] ^ b[1] ^ b[5] ^ b[7];
      wire c1 = b[1] ^ b[2] ^ b[3] ^ b[7];
      wire c2 = b[1] ^ b[3] ^ b[4] ^ b[5];
      wire c3 = ^b;
      // single error flips overall parity; the syndrome names the data bit
      assign ham_nib[g] = {b[7] ^ (~c3 & ~c0 & ~c1 & c2),
                           b[5] ^ (~c3 & ~c0 & c1 & ~c2),
                           b[3] ^ (~c3 & c0 & ~c1 & ~c2),
                           b[1] ^ (~c3 & ~c0 & ~c1 & ~c2)};
      assign ham_bad[g] = c3 & ~(c0 & c1 & c2); // double error: drop line
    end
    for (g = 0; g < vdc_pkg::NUM_OUT_BYTES; g++) begin : g_pack
      assign f2_bytes[8*g +: 8] = {ham_nib[2*g+1], ham_nib[2*g]};
    end
  endgenerate

  // line acceptance by mode and source selection
  wire ttx_mode = mode_control[vdc_pkg::CTRL_MODE_BIT];
  wire alt_sel = mode_control[vdc_pkg::CTRL_FMT_BIT];
  wire hdr_sel = mode_control[vdc_pkg::CTRL_HDR_BIT];
  wire take_l16 = ~ttx_mode & (line_kind == vdc_pkg::VDC_LK_LINE16)
    & ~line_biphase_err;
  wire take_f2 = ttx_mode & ~alt_sel & (line_kind == vdc_pkg::VDC_LK_F2)
    & ~(|ham_bad);
  wire take_f1 = ttx_mode & alt_sel & ~hdr_sel & (line_kind == vdc_pkg::VDC_LK_F1);
  wire take_hdr = ttx_mode & alt_sel & hdr_sel & (line_kind == vdc_pkg::VDC_LK_HEADER);
  wire store = line_valid & ~bus_busy & (take_l16 | take_f2 | take_f1 | take_hdr);
  wire [vdc_pkg::OUT_BITS-1:0] new_bytes = take_f2 ? f2_bytes :
    take_hdr ? {{(vdc_pkg::NUM_OUT_BYTES - vdc_pkg::HDR_BYTES){vdc_pkg::FILL_BYTE}},
                line_data[8*vdc_pkg::HDR_BYTES-1:0]} :
    line_data[vdc_pkg::OUT_BITS-1:0]; // format-1 and line 16 unchanged

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 3'b111;
      sda_q <= 3'b111;
      sel_q <= 2'b00;
    end else begin
      scl_q <= {scl_q[1:0], link.scl};
      sda_q <= {sda_q[1:0], link.sda};
      sel_q <= {sel_q[0], bus_addr_select_pin};
    end
  end

  // transfer register and data-ready output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer <= {vdc_pkg::NUM_OUT_BYTES{vdc_pkg::FILL_BYTE}};
      data_ready_n_out <= 1'b1;
    end else begin
      if (store) begin
        xfer <= new_bytes;
        data_ready_n_out <= 1'b0;
      end else if (rd_addr_acked) begin
        data_ready_n_out <= 1'b1;
      end
    end
  end

  // bus slave: address match, control write, byte reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= vdc_pkg::VDC_D_IDLE;
      mode_control <= vdc_pkg::CTRL_RESET;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      ptr <= 4'h0;
      rw <= 1'b0;
      ack_ok <= 1'b0;
      sda_oe <= 1'b0;
      bus_busy <= 1'b0;
    end else if (start_cond) begin
      state <= vdc_pkg::VDC_D_ADDR;
      bitcnt <= 4'h0;
      ptr <= 4'h0;
      sda_oe <= 1'b0;
      bus_busy <= 1'b1;
    end else if (stop_cond) begin
      state <= vdc_pkg::VDC_D_IDLE;
      sda_oe <= 1'b0;
      bus_busy <= 1'b0;
    end else begin
      case (state)
        vdc_pkg::VDC_D_ADDR, vdc_pkg::VDC_D_WDATA: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_bit};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (state == vdc_pkg::VDC_D_WDATA) begin
              mode_control <= shreg;
              sda_oe <= 1'b1;
              state <= vdc_pkg::VDC_D_WACK;
            end else if (addr_hit) begin
              rw <= shreg[0];
              sda_oe <= 1'b1;
              state <= vdc_pkg::VDC_D_ADDR_ACK;
            end else begin
              state <= vdc_pkg::VDC_D_IGNORE;
            end
          end
        end
        vdc_pkg::VDC_D_ADDR_ACK: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            if (rw) begin
              shreg <= cur_byte;
              sda_oe <= ~cur_byte[7];
              state <= vdc_pkg::VDC_D_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state <= vdc_pkg::VDC_D_WDATA;
            end
          end
        end
        vdc_pkg::VDC_D_WACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= vdc_pkg::VDC_D_IGNORE; // one byte only
          end
        end
        vdc_pkg::VDC_D_RDATA: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (byte_done) begin
              sda_oe <= 1'b0;
              state <= vdc_pkg::VDC_D_RACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6]; // next bit, msb first
            end
          end
        end
        vdc_pkg::VDC_D_RACK: begin
          if (scl_rise) begin
            ack_ok <= ~sda_bit;
            if (!sda_bit) begin
              ptr <= ptr + 4'h1;
            end
          end else if (scl_fall) begin
            if (ack_ok) begin
              bitcnt <= 4'h0;
              shreg <= cur_byte;
              sda_oe <= ~cur_byte[7];
              state <= vdc_pkg::VDC_D_RDATA;
            end else begin
              state <= vdc_pkg::VDC_D_IGNORE;
            end
          end
        end
        vdc_pkg::VDC_D_IDLE, vdc_pkg::VDC_D_IGNORE: ;
        default: state <= vdc_pkg::VDC_D_IDLE;
      endcase
    end
  end

  assign mode_control_out = mode_control;
  assign sys_clk_fast = mode_control[vdc_pkg::CTRL_MODE_BIT];
  assign link.dev_sda_o = 1'b0; // open drain, clock never driven
  assign link.dev_sda_oe = sda_oe;
endmodule
`default_nettype wire

// >>> vdc_host.sv
// controller end: apb register file driving a two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module vdc_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic data_ready_n_in,
  vdc_if.host link
);
  vdc_pkg::vdc_host_state_t state;
  logic [3:0] qcnt;
  logic [1:0] quarter;
  logic [3:0] bitn;
  logic [3:0] byten;
  logic [3:0] cmd_len;
  logic cmd_read;
  logic cmd_sel;
  logic [7:0] tx_byte;
  logic [7:0] rx_sh;
  logic [7:0] rx_buf [0:12];
  logic busy;
  logic nack;
  logic done;
  logic ack_bad;
  logic scl;
  logic sda_oe;
  logic [1:0] sda_sync;
  logic [1:0] rdy_sync;

  // apb decode
  wire acc = psel & penable & ~pready;
  wire wr_cmd = acc & pwrite & (paddr == vdc_pkg::REG_CMD);
  wire wr_tx = acc & pwrite & (paddr == vdc_pkg::REG_TXBYTE);
  wire [4:0] rx_word = paddr[6:2] - vdc_pkg::RX_WORD_BASE;
  wire [3:0] rx_idx = rx_word[3:0];
  wire is_rx = (paddr >= vdc_pkg::REG_RX_FIRST) & (paddr <= vdc_pkg::REG_RX_LAST)
    & (paddr[1:0] == 2'h0);
  wire mapped = (paddr == vdc_pkg::REG_CMD) | (paddr == vdc_pkg::REG_TXBYTE)
    | (paddr == vdc_pkg::REG_STATUS) | is_rx;
  wire go = wr_cmd & pwdata[vdc_pkg::CMD_GO_BIT] & ~busy;
  wire [31:0] rd_mux = (paddr == vdc_pkg::REG_CMD) ?
      {24'h0, cmd_len, 1'b0, cmd_sel, cmd_read, 1'b0} :
    (paddr == vdc_pkg::REG_TXBYTE) ? {24'h0, tx_byte} :
    (paddr == vdc_pkg::REG_STATUS) ? {28'h0, ~rdy_sync[1], done, nack, busy} :
    is_rx ? {24'h0, rx_buf[rx_idx]} : 32'h0;

  // engine timing and bit selection
  wire tick = (qcnt == vdc_pkg::SCL_QUARTER_CYC - 4'h1);
  wire tx_dir = (byten == 4'h0) | ~cmd_read;
  wire [7:0] txb = (byten == 4'h0) ?
    {vdc_pkg::DEV_ADDR_BASE | {6'h0, cmd_sel}, cmd_read} : tx_byte;
  wire [2:0] bsel = 3'(4'h7 - bitn);
  wire [3:0] last_byte = cmd_read ? cmd_len : 4'h1;
  wire more = byten < last_byte;
  wire drive_low = (bitn < vdc_pkg::BITS_PER_BYTE) ? (tx_dir & ~txb[bsel]) :
    (~tx_dir & more);

  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      prdata <= (acc & ~pwrite) ? rd_mux : 32'h0;
      pslverr <= acc & ~mapped;
    end
  end

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync <= 2'b11;
      rdy_sync <= 2'b11;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
      rdy_sync <= {rdy_sync[0], data_ready_n_in};
    end
  end

  // command registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_len <= 4'h0;
      cmd_read <= 1'b0;
      cmd_sel <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      if (wr_cmd & ~busy) begin
        cmd_len <= pwdata[vdc_pkg::CMD_LEN_LSB +: 4];
        cmd_read <= pwdata[vdc_pkg::CMD_READ_BIT];
        cmd_sel <= pwdata[vdc_pkg::CMD_SEL_BIT];
      end
      if (wr_tx) begin
        tx_byte <= pwdata[7:0];
      end
    end
  end

  // bus master sequencer: start, address, data bytes, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= vdc_pkg::VDC_H_IDLE;
      qcnt <= 4'h0;
      quarter <= 2'h0;
      bitn <= 4'h0;
      byten <= 4'h0;
      rx_sh <= 8'h00;
      busy <= 1'b0;
      nack <= 1'b0;
      done <= 1'b0;
      ack_bad <= 1'b0;
      scl <= 1'b1;
      sda_oe <= 1'b0;
      for (int i = 0; i < vdc_pkg::NUM_OUT_BYTES; i++) begin
        rx_buf[i] <= 8'h00;
      end
    end else begin
      if (wr_cmd) begin
        done <= 1'b0;
      end
      qcnt <= (state == vdc_pkg::VDC_H_IDLE || tick) ? 4'h0 : qcnt + 4'h1;
      if (state != vdc_pkg::VDC_H_IDLE && tick) begin
        quarter <= quarter + 2'h1;
      end
      case (state)
        vdc_pkg::VDC_H_IDLE: begin
          quarter <= 2'h0;
          if (go & sda_sync[1]) begin
            state <= vdc_pkg::VDC_H_START;
            busy <= 1'b1;
            nack <= 1'b0;
            byten <= 4'h0;
            bitn <= 4'h0;
          end
        end
        vdc_pkg::VDC_H_START: begin
          if (tick) begin
            case (quarter)
              2'h0: sda_oe <= 1'b1; // data falls with clock high
              2'h2: scl <= 1'b0;
              2'h3: state <= vdc_pkg::VDC_H_BIT;
              default: ;
            endcase
          end
        end
        vdc_pkg::VDC_H_BIT: begin
          if (tick) begin
            case (quarter)
              2'h0: sda_oe <= drive_low;
              2'h1: scl <= 1'b1;
              2'h2: begin
                if (bitn < vdc_pkg::BITS_PER_BYTE) begin
                  rx_sh <= {rx_sh[6:0], sda_sync[1]};
                end else begin
                  ack_bad <= tx_dir & sda_sync[1];
                end
              end
              default: begin
                scl <= 1'b0;
                if (bitn == vdc_pkg::BITS_PER_BYTE) begin
                  bitn <= 4'h0;
                  byten <= byten + 4'h1;
                  if (~tx_dir && byten <= vdc_pkg::NUM_OUT_BYTES) begin
                    rx_buf[byten - 4'h1] <= rx_sh;
                  end
                  if (ack_bad) begin
                    nack <= 1'b1;
                    state <= vdc_pkg::VDC_H_STOP;
                  end else if (!more) begin
                    state <= vdc_pkg::VDC_H_STOP;
                  end
                end else begin
                  bitn <= bitn + 4'h1;
                end
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            case (quarter)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl <= 1'b1;
              2'h2: sda_oe <= 1'b0; // data rises with clock high
              default: begin
                state <= vdc_pkg::VDC_H_IDLE;
                busy <= 1'b0;
                done <= 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  assign link.scl = scl;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_oe;
endmodule
`default_nettype wire

// >>> vdc_if.sv
// two-wire link between the capture device and its controller
`timescale 1ns/1ps
`default_nettype none
interface vdc_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // open-drain data line: any enabled low output pulls it down
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// >>> vdc_link_chk.sv
// wire checks on the two-wire link between controller and capture device
`timescale 1ns/1ps
`default_nettype none
module vdc_link_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic scl_q;
  logic sda_q;
  logic act;
  logic first;
  logic [3:0] cnt;
  // start, stop and clock rise against the last sampled levels
  wire logic start_ev = scl & scl_q & sda_q & ~sda;
  wire logic stop_ev = scl & scl_q & ~sda_q & sda;
  wire logic rise_ev = scl & ~scl_q;
  wire logic ninth = rise_ev & (cnt == 4'h8);
  wire logic next_act = start_ev | (act & ~stop_ev);
  wire logic [3:0] next_cnt = (start_ev | ninth) ? 4'h0 : cnt + {3'h0, rise_ev};
  wire logic next_first = start_ev | (first & ~ninth);
  // framing tracker: busy span, first byte, bit position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      act <= 1'b0;
      first <= 1'b0;
      cnt <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      act <= next_act;
      first <= next_first;
      cnt <= next_cnt;
    end
  end
  a_open_drain: assert property (!dev_sda_o && !host_sda_o)
    else $error("sda driven high");
  a_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("device data moved near clock high");
  a_dev_idle: assert property (!act |-> !dev_sda_oe)
    else $error("device drives outside a transfer");
  a_start_idle: assert property (start_ev |-> !act)
    else $error("start on a busy bus");
  a_host_framing: assert property (scl && $past(scl) && $changed(host_sda_oe) |-> host_sda_oe != act)
    else $error("master data moved while clock high");
  a_scl_width: assert property (rise_ev |-> scl [*8])
    else $error("clock high phase too short");
  a_addr_host: assert property (rise_ev && first && cnt < 4'h8 |-> !dev_sda_oe)
    else $error("device drives during address");
  a_addr_release: assert property (ninth && first |-> !host_sda_oe)
    else $error("master holds data in ninth bit");
  a_stop_free: assert property (stop_ev |-> !dev_sda_oe && !$past(dev_sda_oe))
    else $error("device drives at stop");
endmodule
`default_nettype wire

// >>> vdc_pkg.sv
// shared constants and types for the vbi data capture link
package vdc_pkg;
  // system clock and sync-locked acquisition clock rates
  localparam int unsigned PCLK_MHZ = 25;
  localparam int unsigned SYSCLK_LINE16_KHZ = 10000;
  localparam int unsigned SYSCLK_TTX_KHZ = 13875;
  // serial bus addressing: 20h/21h with select low, 22h/23h with select high
  localparam logic [6:0] DEV_ADDR_BASE = 7'h10;
  // mode_control layout
  localparam int CTRL_FMT_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_HDR_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // transfer register and line geometry
  localparam int NUM_OUT_BYTES = 13;
  localparam int NUM_HAM_BYTES = 26;
  localparam int HDR_BYTES = 8;
  localparam int OUT_BITS = 104;
  localparam int LINE_BITS = 208;
  localparam logic [3:0] LAST_PTR = 4'hC;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    VDC_LK_NONE = 3'b000,
    VDC_LK_LINE16 = 3'b001,
    VDC_LK_F1 = 3'b010,
    VDC_LK_F2 = 3'b011,
    VDC_LK_HEADER = 3'b100
  } vdc_line_t;
  typedef enum logic [2:0] {
    VDC_D_IDLE = 3'b000,
    VDC_D_ADDR = 3'b001,
    VDC_D_ADDR_ACK = 3'b010,
    VDC_D_WDATA = 3'b011,
    VDC_D_WACK = 3'b100,
    VDC_D_RDATA = 3'b101,
    VDC_D_RACK = 3'b110,
    VDC_D_IGNORE = 3'b111
  } vdc_dev_state_t;
  typedef enum logic [1:0] {
    VDC_H_IDLE = 2'b00,
    VDC_H_START = 2'b01,
    VDC_H_BIT = 2'b10,
    VDC_H_STOP = 2'b11
  } vdc_host_state_t;
  // serial clock made by the controller: four quarters per bit
  localparam int unsigned SCL_QUARTER_NS = 160;
  localparam int unsigned SCL_QUARTER_CYC_I = (SCL_QUARTER_NS * PCLK_MHZ) / 1000;
  localparam logic [3:0] SCL_QUARTER_CYC = 4'(SCL_QUARTER_CYC_I);
  // controller register map (byte addresses)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_TXBYTE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RX_FIRST = 8'h10;
  localparam logic [7:0] REG_RX_LAST = 8'h40;
  localparam logic [4:0] RX_WORD_BASE = 5'h04;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_SEL_BIT = 2;
  localparam int CMD_LEN_LSB = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_NACK_BIT = 1;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_READY_BIT = 3;
endpackage
